// ---- rtci_irq_top.sv ----
// Clock/calendar interrupt source logic with flag register and request output
//
// Operation
// - Six periodic sources, each with own enable
// - Any request sets the clock interrupt flag
// - Writing 0 clears the clock interrupt flag
// - Overflow enable gives request on counter wrap
// - Week enable gives request at weekday 0
// - Day enable gives request per day advance
// - Hour enable gives request per hour advance
// - Minute enable gives request per minute advance
// - Second enable gives request per second advance
module rtci_irq_top
  import rtci_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                resetn_i,
  input  wire rtci_pkg::rtci_evt_s evt_i,
  input  wire rtci_pkg::rtci_req_s req_i,
  output logic [7:0]               rdata_o,
  output logic                     irq_o
);
  import rtci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] ctrl_two;   // Second clock control register
    logic       flag;       // Clock interrupt flag
    logic [7:0] rdata;
    logic       irq;
  } rtci_state_s;

  rtci_state_s st_q;
  rtci_state_s st_d;
  logic        hit;
  logic [5:0]  last_src;

  // Address match helper, used for reads and writes
  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction : is_addr

  ////////////////////////////////////////////////////////////////////////////
  // Source gating

  rtci_src_sel u_sel (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .evt_i      (evt_i),
    .enables_i  (st_q.ctrl_two),
    .hit_o      (hit),
    .last_src_o (last_src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d       = st_q;
    st_d.rdata = UNMAPPED_READ_VAL;
    // Control writes; the block trusts software to set only one enable
    if (req_i.wr && is_addr(req_i.addr, CLOCK_CTRL_REG_TWO_OFS)) begin
      st_d.ctrl_two = {2'b00, req_i.wdata[5:0]};
    end
    if (req_i.wr && is_addr(req_i.addr, IRQ_FLAG_REG_ONE_OFS) &&
        !req_i.wdata[CLOCK_IRQ_FLAG_BIT]) begin
      st_d.flag = 1'b0;
    end
    // hit (registered one cycle after the event) sets flag, winning over a same-cycle clear
    if (hit) begin
      st_d.flag = 1'b1;
    end
    // Reads answer one cycle later; other offsets read zero
    if (req_i.rd) begin
      if (is_addr(req_i.addr, CLOCK_CTRL_REG_TWO_OFS)) begin
        st_d.rdata = st_q.ctrl_two;
      end else if (is_addr(req_i.addr, IRQ_FLAG_REG_ONE_OFS)) begin
        st_d.rdata = {7'h00, st_q.flag};
      end else if (is_addr(req_i.addr, EVENT_STAT_OFS)) begin
        st_d.rdata = {2'b00, last_src};
      end
    end
    st_d.irq = st_d.flag;
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q.ctrl_two <= CLOCK_CTRL_REG_TWO_RST;
      st_q.flag     <= CLOCK_IRQ_FLAG_RST;
      st_q.rdata    <= 8'h00;
      st_q.irq      <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign irq_o   = st_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_flag_ovf_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.overflow && st_q.ctrl_two[OVERFLOW_IRQ_EN_BIT] |-> ##2 st_q.flag)
    else $error("overflow event did not set flag");

  chk_flag_week_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.dow_zero && st_q.ctrl_two[WEEK_IRQ_EN_BIT] |-> ##2 st_q.flag)
    else $error("week event did not set flag");

  chk_flag_day_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.day_tick && st_q.ctrl_two[DAY_IRQ_EN_BIT] |-> ##2 st_q.flag)
    else $error("day event did not set flag");

  chk_flag_hour_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.hour_tick && st_q.ctrl_two[HOUR_IRQ_EN_BIT] |-> ##2 st_q.flag)
    else $error("hour event did not set flag");

  chk_flag_min_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.min_tick && st_q.ctrl_two[MINUTE_IRQ_EN_BIT] |-> ##2 st_q.flag)
    else $error("minute event did not set flag");

  chk_flag_sec_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.sec_tick && st_q.ctrl_two[SECOND_IRQ_EN_BIT] |-> ##2 st_q.flag)
    else $error("second event did not set flag");

  chk_flag_no_cause: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(st_q.flag) |-> $past(hit))
    else $error("flag rose without enabled event");

  chk_flag_set_src: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit |=> st_q.flag)
    else $error("request did not set flag");

  chk_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    req_i.wr && req_i.addr == IRQ_FLAG_REG_ONE_OFS && !req_i.wdata[0] && !hit |=> !st_q.flag)
    else $error("write of zero did not clear flag");

  chk_irq_follow: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    irq_o == st_q.flag)
    else $error("request does not follow flag");

  ////////////////////////////////////////////////////////////////////////////
  // Check-side decode

  // Rebuilt apart from the next-state logic, so a slip in either one shows
  logic       mon_wr_ctrl;   // Write to the second control register
  logic       mon_wr_flag;   // Write to the first flag register
  logic       mon_clr_flag;  // That write carries a 0 in the flag bit
  logic       mon_rd_ctrl;
  logic       mon_rd_flag;
  logic       mon_rd_stat;
  logic       mon_rd_other;  // Read of an offset the block does not map
  logic [5:0] mon_evt_vec;   // Events at their enable bit positions
  logic [5:0] mon_en_evt;    // Events whose enable is set

  // Port strobes against the register map
  assign mon_wr_ctrl  = req_i.wr && (req_i.addr == CLOCK_CTRL_REG_TWO_OFS);
  assign mon_wr_flag  = req_i.wr && (req_i.addr == IRQ_FLAG_REG_ONE_OFS);
  assign mon_clr_flag = mon_wr_flag && !req_i.wdata[CLOCK_IRQ_FLAG_BIT];
  assign mon_rd_ctrl  = req_i.rd && (req_i.addr == CLOCK_CTRL_REG_TWO_OFS);
  assign mon_rd_flag  = req_i.rd && (req_i.addr == IRQ_FLAG_REG_ONE_OFS);
  assign mon_rd_stat  = req_i.rd && (req_i.addr == EVENT_STAT_OFS);
  assign mon_rd_other = req_i.rd && !mon_rd_ctrl && !mon_rd_flag && !mon_rd_stat;

  // Events placed by field name, not by struct order, to catch a mix-up
  always_comb begin
    mon_evt_vec                      = '0;
    mon_evt_vec[OVERFLOW_IRQ_EN_BIT] = evt_i.overflow;
    mon_evt_vec[WEEK_IRQ_EN_BIT]     = evt_i.dow_zero;
    mon_evt_vec[DAY_IRQ_EN_BIT]      = evt_i.day_tick;
    mon_evt_vec[HOUR_IRQ_EN_BIT]     = evt_i.hour_tick;
    mon_evt_vec[MINUTE_IRQ_EN_BIT]   = evt_i.min_tick;
    mon_evt_vec[SECOND_IRQ_EN_BIT]   = evt_i.sec_tick;
  end

  // Enabled events as the selector should see them in this cycle
  assign mon_en_evt = mon_evt_vec & st_q.ctrl_two[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks: source selection

  // A hit follows an enabled event by one cycle, and nothing else makes one
  chk_src_hit_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_en_evt != 6'h00 |=> hit)
    else $error("enabled event gave no hit");

  chk_src_hit_cause: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit |-> $past(mon_en_evt != 6'h00))
    else $error("hit without enabled event");

  chk_src_off_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_evt_vec != 6'h00 && mon_en_evt == 6'h00 |=> !hit)
    else $error("disabled event gave a hit");

  // Each enabled event marks its own bit in the status register
  chk_stat_ovf_bit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.overflow && st_q.ctrl_two[OVERFLOW_IRQ_EN_BIT] |=> last_src[OVERFLOW_IRQ_EN_BIT])
    else $error("overflow event not marked in status");

  chk_stat_week_bit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.dow_zero && st_q.ctrl_two[WEEK_IRQ_EN_BIT] |=> last_src[WEEK_IRQ_EN_BIT])
    else $error("week event not marked in status");

  chk_stat_day_bit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.day_tick && st_q.ctrl_two[DAY_IRQ_EN_BIT] |=> last_src[DAY_IRQ_EN_BIT])
    else $error("day event not marked in status");

  chk_stat_hour_bit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.hour_tick && st_q.ctrl_two[HOUR_IRQ_EN_BIT] |=> last_src[HOUR_IRQ_EN_BIT])
    else $error("hour event not marked in status");

  chk_stat_min_bit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.min_tick && st_q.ctrl_two[MINUTE_IRQ_EN_BIT] |=> last_src[MINUTE_IRQ_EN_BIT])
    else $error("minute event not marked in status");

  chk_stat_sec_bit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    evt_i.sec_tick && st_q.ctrl_two[SECOND_IRQ_EN_BIT] |=> last_src[SECOND_IRQ_EN_BIT])
    else $error("second event not marked in status");

  // Status keeps the last source while no enabled event arrives
  chk_stat_keep: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_en_evt == 6'h00 |=> $stable(last_src))
    else $error("status changed without enabled event");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: flag and request

  // Set wins over a clear in the same cycle
  chk_flag_set_wins: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit && mon_clr_flag |=> st_q.flag)
    else $error("clear beat a same-cycle event");

  // Once set, only a write of 0 in the flag bit takes the flag down
  chk_flag_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_q.flag && !mon_clr_flag |=> st_q.flag)
    else $error("flag dropped without a clearing write");

  chk_flag_one_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_wr_flag && req_i.wdata[CLOCK_IRQ_FLAG_BIT] |=> st_q.flag == ($past(st_q.flag) || $past(hit)))
    else $error("write of one changed the flag");

  // Without an event the flag cannot come up
  chk_flag_stay_low: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !st_q.flag && !hit |=> !st_q.flag)
    else $error("flag rose without a hit");

  // Request edges each have their own cause one cycle earlier
  chk_irq_rise_cause: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(irq_o) |-> $past(hit))
    else $error("request rose without a hit");

  chk_irq_fall_cause: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $fell(irq_o) |-> $past(mon_clr_flag && !hit))
    else $error("request fell without a clearing write");

  chk_irq_hold_set: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    irq_o && !mon_clr_flag |=> irq_o)
    else $error("request dropped while flag set");

  chk_irq_low_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !irq_o && !hit |=> !irq_o)
    else $error("request raised without a hit");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: register port

  // Control register takes the six enable bits, upper two read as 0
  chk_ctrl_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_wr_ctrl |=> st_q.ctrl_two == {2'b00, $past(req_i.wdata[5:0])})
    else $error("control write not taken");

  chk_ctrl_keep: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !mon_wr_ctrl |=> $stable(st_q.ctrl_two))
    else $error("control changed without a write");

  chk_ctrl_top_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_q.ctrl_two[7:6] == 2'b00)
    else $error("control upper bits not zero");

  // Read data stand for one cycle after the strobe, then return to 0
  chk_rdata_ctrl: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_rd_ctrl |=> rdata_o == $past(st_q.ctrl_two))
    else $error("control read data wrong");

  chk_rdata_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_rd_flag |=> rdata_o[CLOCK_IRQ_FLAG_BIT] == $past(st_q.flag))
    else $error("flag read data wrong");

  chk_rdata_stat: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_rd_stat |=> rdata_o == {2'b00, $past(last_src)})
    else $error("status read data wrong");

  chk_rdata_other: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    mon_rd_other |=> rdata_o == UNMAPPED_READ_VAL)
    else $error("unmapped read data not zero");

  chk_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !req_i.rd |=> rdata_o == UNMAPPED_READ_VAL)
    else $error("read data held past one cycle");

endmodule : rtci_irq_top

// ---- rtci_pkg.sv ----
// Package: register map, field layout and event encodings of the clock interrupt sources
package rtci_pkg;

  // Register offsets (8-bit data on a plain register port)
  localparam logic [15:0] IRQ_FLAG_REG_ONE_OFS   = 16'hFFF6;
  localparam logic [15:0] CLOCK_CTRL_REG_TWO_OFS = 16'hFFE0;
  localparam logic [15:0] EVENT_STAT_OFS         = 16'hFFE1;

  // Flag bit inside the first interrupt flag register
  localparam int unsigned CLOCK_IRQ_FLAG_BIT = 0;

  // Enable field positions in the second clock control register
  localparam int unsigned SECOND_IRQ_EN_BIT   = 0;
  localparam int unsigned MINUTE_IRQ_EN_BIT   = 1;
  localparam int unsigned HOUR_IRQ_EN_BIT     = 2;
  localparam int unsigned DAY_IRQ_EN_BIT      = 3;
  localparam int unsigned WEEK_IRQ_EN_BIT     = 4;
  localparam int unsigned OVERFLOW_IRQ_EN_BIT = 5;

  // Reset values
  localparam logic [7:0] CLOCK_CTRL_REG_TWO_RST = 8'h00;
  localparam logic       CLOCK_IRQ_FLAG_RST     = 1'b0;
  localparam logic [7:0] UNMAPPED_READ_VAL      = 8'h00;

  // Number of interrupt sources
  localparam int unsigned NUM_SRC = 6;

  // Timebase events from the clock/calendar counters, one-cycle pulses
  typedef struct packed {
    logic overflow;   // Free-running counter wrapped
    logic dow_zero;   // Day-of-week counter became 0
    logic day_tick;   // Day-of-week counter advanced
    logic hour_tick;  // Hour counter advanced
    logic min_tick;   // Minute counter advanced
    logic sec_tick;   // Second counter advanced
  } rtci_evt_s;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } rtci_req_s;

endpackage : rtci_pkg

// ---- rtci_src_sel.sv ----
// Source selection: gates timebase events by their enable bits
module rtci_src_sel
  import rtci_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                resetn_i,
  input  wire rtci_pkg::rtci_evt_s evt_i,
  input  wire logic [7:0]          enables_i,
  output logic                     hit_o,
  output logic [5:0]               last_src_o
);
  import rtci_pkg::*;

  typedef struct packed {
    logic       hit;
    logic [5:0] last_src;
  } rtci_sel_state_s;

  rtci_sel_state_s st_q;
  rtci_sel_state_s st_d;
  logic [5:0]      gated;

  // Per-source gating, each event placed at its own enable bit by name
  always_comb begin
    gated                      = '0;
    gated[OVERFLOW_IRQ_EN_BIT] = evt_i.overflow & enables_i[OVERFLOW_IRQ_EN_BIT];
    gated[WEEK_IRQ_EN_BIT]     = evt_i.dow_zero & enables_i[WEEK_IRQ_EN_BIT];
    gated[DAY_IRQ_EN_BIT]      = evt_i.day_tick & enables_i[DAY_IRQ_EN_BIT];
    gated[HOUR_IRQ_EN_BIT]     = evt_i.hour_tick & enables_i[HOUR_IRQ_EN_BIT];
    gated[MINUTE_IRQ_EN_BIT]   = evt_i.min_tick & enables_i[MINUTE_IRQ_EN_BIT];
    gated[SECOND_IRQ_EN_BIT]   = evt_i.sec_tick & enables_i[SECOND_IRQ_EN_BIT];
    st_d     = st_q;
    st_d.hit = |gated;
    // Remember which source fired last, for software diagnosis
    if (|gated) begin
      st_d.last_src = gated;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hit_o      = st_q.hit;
  assign last_src_o = st_q.last_src;

endmodule : rtci_src_sel

// ---- rtci_cpu_model.sv ----
// Interrupt controller model that counts requests raised by the block
module rtci_cpu_model (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic irq_i,
  output int        n_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_q;
  // request is a level, so count its rising edges only
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_q   <= 1'b0;
      n_req_o <= 0;
    end else begin
      irq_q <= irq_i;
      if (irq_i && !irq_q) n_req_o <= n_req_o + 1;
    end
  end
endmodule : rtci_cpu_model

// ---- rtci_irq_top_test.sv ----
// Self-checking bench for the clock interrupt source block
module rtci_irq_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rtci_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  rtci_evt_s  evt = '0;
  rtci_req_s  req = '0;
  logic [7:0] rdata;
  logic       irq;
  logic [7:0] en;
  logic [7:0] ev;
  bit         exp_flag;
  int         n_req;
  int         n_exp = 0;
  int         cyc = 0;
  int         n_fail = 0;
  int         total_checks = 0;
  rtci_irq_top u_dut (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .evt_i     (evt),
    .req_i     (req),
    .rdata_o   (rdata),
    .irq_o     (irq)
  );
  rtci_cpu_model u_cpu (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .irq_i(irq), .n_req_o(n_req));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; ceiling far above the few hundred cycles needed
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_reg
  task automatic check_irq(input logic got, input logic exp);
    check_reg({7'h00, got}, {7'h00, exp});
  endtask : check_irq
  // Register port: one-cycle strobes, read data one cycle after the strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Event pulse for one cycle, then the two edges until the request shows
  task automatic pulse(input logic [5:0] v);
    @(posedge sys_clk_i);
    evt <= rtci_evt_s'(v);
    @(posedge sys_clk_i);
    evt <= '0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    if ((v & en[5:0]) != 0 && !exp_flag) n_exp++;
    if ((v & en[5:0]) != 0) exp_flag = 1'b1;
  endtask : pulse
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: each source alone, with random neighbours that must not fire
  initial begin
    logic [7:0] d;
    void'($urandom(74196));
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(CLOCK_CTRL_REG_TWO_OFS, d);
    check_reg(d, CLOCK_CTRL_REG_TWO_RST);
    rd(16'h0000, d);
    check_reg(d, UNMAPPED_READ_VAL);
    for (int i = 0; i < NUM_SRC; i++) begin
      // enable set up first, and only one at a time
      en = 8'h01 << i;
      // Bits 7:6 are not enables and must read back as 0
      wr(CLOCK_CTRL_REG_TWO_OFS, en | 8'hC0);
      rd(CLOCK_CTRL_REG_TWO_OFS, d);
      check_reg(d, en);
      for (int k = 0; k < 4; k++) begin
        ev = 8'($urandom_range(0, 63));
        if (k == 0) ev = ev & ~en;
        pulse(ev[5:0]);
        check_irq(irq, exp_flag);
      end
      pulse(en[5:0]);
      check_irq(irq, 1'b1);
      rd(EVENT_STAT_OFS, d);
      check_reg(d, en);
      rd(IRQ_FLAG_REG_ONE_OFS, d);
      check_reg(d, 8'h01);
      // Read data stand for one cycle only
      @(posedge sys_clk_i);
      #1 check_reg(rdata, UNMAPPED_READ_VAL);
      // Random upper bits with the flag bit at 1: no effect
      wr(IRQ_FLAG_REG_ONE_OFS, 8'($urandom) | 8'h01);
      repeat (2) @(posedge sys_clk_i);
      #1 check_irq(irq, 1'b1);
      wr(IRQ_FLAG_REG_ONE_OFS, 8'($urandom) & 8'hFE);
      exp_flag = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 check_irq(irq, 1'b0);
      rd(IRQ_FLAG_REG_ONE_OFS, d);
      check_reg(d, 8'h00);
    end
    // Clearing write one cycle after the event meets its hit in one cycle: the set wins
    @(posedge sys_clk_i);
    evt <= rtci_evt_s'(en[5:0]);
    @(posedge sys_clk_i);
    evt <= '0;
    req <= '{addr: IRQ_FLAG_REG_ONE_OFS, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
    n_exp++;
    exp_flag = 1'b1;
    @(posedge sys_clk_i);
    #1 check_irq(irq, exp_flag);
    wr(IRQ_FLAG_REG_ONE_OFS, 8'h00);
    exp_flag = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 check_irq(irq, exp_flag);
    check_reg(8'(n_req), 8'(n_exp));
    give_verdict();
  end
endmodule : rtci_irq_top_test
